// ---- inc/plk_pkg.sv ----
// link control, link status and slot capability register definitions
package plk_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] LINK_CTL_IDX = 12'h050;
  localparam logic [11:0] LINK_STS_IDX = 12'h052;
  localparam logic [11:0] SLOT_CAP_IDX = 12'h054;
  localparam logic [11:0] PORT_CFG_IDX = 12'h060;
  localparam logic [11:0] LINK_CTL_ADDR = 12'(LINK_CTL_IDX * 4);
  localparam logic [11:0] LINK_STS_ADDR = 12'(LINK_STS_IDX * 4);
  localparam logic [11:0] SLOT_CAP_ADDR = 12'(SLOT_CAP_IDX * 4);
  localparam logic [11:0] PORT_CFG_ADDR = 12'(PORT_CFG_IDX * 4);

  // link_control_upper fields
  localparam int CTL_RETRAIN = 5;
  localparam int CTL_CLK_PM = 8;
  localparam int CTL_AUTO_WIDTH = 9;
  localparam int CTL_BW_MGMT_EN = 10;
  localparam int CTL_AUTO_BW_EN = 11;

  // link_state_report fields
  localparam int STS_SPEED_LSB = 0;
  localparam int STS_WIDTH_LSB = 4;
  localparam int STS_TRAIN_FAIL = 10;
  localparam int STS_TRAIN_ACTIVE = 11;
  localparam int STS_SLOT_CLK = 12;
  localparam int STS_DL_ACTIVE = 13;
  localparam int STS_BW_MGMT_FLAG = 14;
  localparam int STS_AUTO_BW_FLAG = 15;

  // slot_feature_report fields
  localparam int SCAP_ATTEN_BTN = 0;
  localparam int SCAP_PWR_CTRL = 1;

  // port configuration fields
  localparam int CFG_LEGACY = 0;
  localparam int CFG_BW_CAP = 1;
  localparam int CFG_SLOT = 2;
  localparam int CFG_DL_CAP = 3;

  // reset values
  localparam logic [3:0] SPEED_RST = 4'h1;
  localparam logic [5:0] WIDTH_RST = 6'h00;
  localparam logic CFG_LEGACY_RST = 1'b0;
  localparam logic CFG_SLOT_RST = 1'b0;
  localparam logic CFG_DL_CAP_RST = 1'b1;

  // consecutive training sets that mark an autonomous change
  localparam int TS_RUN_LEN = 8;

  typedef struct packed {
    logic [3:0] cur_speed;
    logic [5:0] neg_width;
    logic train_fail;
    logic train_active;
    logic dl_up;
    logic retrain_done;
    logic reliable_fix_change;
    logic auto_change;
  } plk_link_status_t;

  typedef struct packed {
    logic valid;
    logic auto_change_bit;
  } plk_ts_rx_t;
endpackage

// ---- hw/plk_ts_run.sv ----
// counter of consecutive training sets carrying the autonomous change bit
`timescale 1ns/10ps
`default_nettype none
module plk_ts_run #(
  parameter int RUN_LEN = plk_pkg::TS_RUN_LEN
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire plk_pkg::plk_ts_rx_t ts_rx,
  output logic run_hit
);
  localparam int CW = $clog2(RUN_LEN + 1);
  localparam logic [CW-1:0] LAST = CW'(RUN_LEN - 1);
  localparam logic [CW-1:0] FULL = CW'(RUN_LEN);

  logic [CW-1:0] run_cnt;

  // saturates at the full run so one run yields one pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt <= '0;
    end else if (ts_rx.valid) begin
      if (!ts_rx.auto_change_bit) begin
        run_cnt <= '0;
      end else if (run_cnt != FULL) begin
        run_cnt <= run_cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_hit <= 1'b0;
    end else begin
      run_hit <= ts_rx.valid & ts_rx.auto_change_bit & (run_cnt == LAST);
    end
  end

  chk_ts_run_hit: assert property ( // [RL16]
    @(posedge pclk) disable iff (!presetn)
    (ts_rx.valid && ts_rx.auto_change_bit && run_cnt == LAST) |=> run_hit)
    else $error("run of training sets did not raise hit");
  chk_ts_run_break: assert property ( // [RL16]
    @(posedge pclk) disable iff (!presetn)
    (ts_rx.valid && !ts_rx.auto_change_bit) |=> !run_hit ##1 !run_hit)
    else $error("hit raised after a broken run");
endmodule
`default_nettype wire

// ---- hw/plk_regs.sv ----
// link control/status and slot capability registers of one switch port
// Contract
// [RL1] width-change disable set: no autonomous width change except narrowing.
// [RL2] legacy mode: width disable, bandwidth enables and flags read zero.
// [RL3] bandwidth management enable lets its flag raise an interrupt.
// [RL4] autonomous bandwidth enable lets its flag raise an interrupt.
// [RL5] notification capability clear: bandwidth enables and flags read zero.
// [RL6] clock power management enable is read-only zero.
// [RL7] current speed reports 1 or 2, resets to one.
// [RL8] negotiated width field reports the trained link width.
// [RL9] training error bit flags a training failure.
// [RL10] training-in-progress bit is one while training runs.
// [RL11] slot clock starts from the port's common-clock strap, writable.
// [RL12] data-link-active follows the link layer, zero without capability.
// [RL13] retrain done without link down sets bandwidth flag, write-one clears.
// [RL14] reliability-driven speed or width change also sets that flag.
// [RL15] other autonomous speed or width change sets autonomous flag.
// [RL16] downstream port: eight consecutive marked training sets set it.
// [RL17] slot button and power controller bits writable only with slot.
// [RL18] notification capability is zero on the upstream port.
// [RL19] retrain request write sends LTSSM to recovery, reads zero.
// [RL20] interrupt while any enabled bandwidth flag stays set.
`timescale 1ns/10ps
`default_nettype none
module plk_regs #(
  parameter bit UPSTREAM = 1'b0,
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire plk_pkg::plk_link_status_t link_st,
  input wire plk_pkg::plk_ts_rx_t ts_rx,
  input wire logic upstream_commonclk_strap,
  input wire logic downstream_commonclk_strap,
  output logic retrain_request,
  output logic auto_width_disable,
  output logic port_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    is_mapped = (a == plk_pkg::LINK_CTL_ADDR) ||
                (a == plk_pkg::LINK_STS_ADDR) ||
                (a == plk_pkg::SLOT_CAP_ADDR) ||
                (a == plk_pkg::PORT_CFG_ADDR);
  endfunction

  // ---- bus handshake: one wait state, then pready
  logic access;
  logic commit;
  logic wr_ctl;
  logic wr_sts;
  logic wr_scap;
  logic wr_cfg;
  logic [31:0] rd_word;

  assign access = psel & penable & ~pready;
  assign commit = psel & penable & pready & pwrite & is_mapped(paddr);
  assign wr_ctl = commit & (paddr == plk_pkg::LINK_CTL_ADDR);
  assign wr_sts = commit & (paddr == plk_pkg::LINK_STS_ADDR);
  assign wr_scap = commit & (paddr == plk_pkg::SLOT_CAP_ADDR);
  assign wr_cfg = commit & (paddr == plk_pkg::PORT_CFG_ADDR);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & ~is_mapped(paddr);
      if (access) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // ---- port configuration
  logic cfg_legacy;
  logic cfg_bw_cap;
  logic cfg_slot;
  logic cfg_dl_cap;
  logic bw_cap_eff;
  logic bw_ok;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_legacy <= plk_pkg::CFG_LEGACY_RST;
      cfg_bw_cap <= ~UPSTREAM;
      cfg_slot <= plk_pkg::CFG_SLOT_RST;
      cfg_dl_cap <= plk_pkg::CFG_DL_CAP_RST;
    end else if (wr_cfg && pstrb[0]) begin
      cfg_legacy <= pwdata[plk_pkg::CFG_LEGACY];
      cfg_bw_cap <= pwdata[plk_pkg::CFG_BW_CAP];
      cfg_slot <= pwdata[plk_pkg::CFG_SLOT];
      cfg_dl_cap <= pwdata[plk_pkg::CFG_DL_CAP];
    end
  end

  assign bw_cap_eff = cfg_bw_cap & ~UPSTREAM; // [RL18]
  assign bw_ok = bw_cap_eff & ~cfg_legacy; // [RL2] [RL5]

  // ---- link control upper half
  logic ctl_auto_width;
  logic ctl_bw_en;
  logic ctl_abw_en;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_auto_width <= 1'b0;
    end else if (cfg_legacy) begin
      ctl_auto_width <= 1'b0; // [RL2]
    end else if (wr_ctl && pstrb[1]) begin
      ctl_auto_width <= pwdata[plk_pkg::CTL_AUTO_WIDTH];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_bw_en <= 1'b0;
      ctl_abw_en <= 1'b0;
    end else if (!bw_ok) begin
      ctl_bw_en <= 1'b0; // [RL2] [RL5]
      ctl_abw_en <= 1'b0;
    end else if (wr_ctl && pstrb[1]) begin
      ctl_bw_en <= pwdata[plk_pkg::CTL_BW_MGMT_EN];
      ctl_abw_en <= pwdata[plk_pkg::CTL_AUTO_BW_EN];
    end
  end

  // physical layer holds width while this is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_width_disable <= 1'b0;
    end else begin
      auto_width_disable <= ctl_auto_width & ~cfg_legacy; // [RL1]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retrain_request <= 1'b0;
    end else begin
      retrain_request <= wr_ctl & pstrb[0] &
                         pwdata[plk_pkg::CTL_RETRAIN]; // [RL19]
    end
  end

  // ---- link layer status, same clock
  plk_pkg::plk_link_status_t st_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '{cur_speed: plk_pkg::SPEED_RST,
                neg_width: plk_pkg::WIDTH_RST,
                default: 1'b0};
    end else begin
      st_q <= link_st; // [RL7] [RL8] [RL9] [RL10]
    end
  end

  // ---- slot clock strap: three stages, taken once settled
  logic strap_pin;
  logic [2:0] strap_sync;
  logic slot_clk;
  logic slot_clk_loaded;

  assign strap_pin = UPSTREAM ? upstream_commonclk_strap :
                     downstream_commonclk_strap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_sync <= 3'h0;
    end else begin
      strap_sync <= {strap_sync[1:0], strap_pin};
    end
  end

  // waits until the pin value has reached the last stage
  logic [2:0] strap_fill;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_fill <= 3'h0;
    end else begin
      strap_fill <= {strap_fill[1:0], 1'b1};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_clk <= 1'b0;
      slot_clk_loaded <= 1'b0;
    end else if (wr_sts && pstrb[1]) begin
      slot_clk <= pwdata[plk_pkg::STS_SLOT_CLK]; // [RL11]
      slot_clk_loaded <= 1'b1;
    end else if (!slot_clk_loaded && strap_fill[2] &&
                 strap_sync[1] == strap_sync[2]) begin
      slot_clk <= strap_sync[2]; // [RL11]
      slot_clk_loaded <= 1'b1;
    end
  end

  // ---- bandwidth event flags
  logic retrain_pend;
  logic ts_hit;
  logic bw_flag;
  logic abw_flag;
  logic set_bw;
  logic set_abw;
  logic clr_bw;
  logic clr_abw;

  plk_ts_run #(
    .RUN_LEN(plk_pkg::TS_RUN_LEN)
  ) u_ts_run (
    .pclk(pclk),
    .presetn(presetn),
    .ts_rx(ts_rx),
    .run_hit(ts_hit)
  );

  // a trip through link down cancels the pending retrain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      retrain_pend <= 1'b0;
    end else if (retrain_request) begin
      retrain_pend <= 1'b1;
    end else if (!st_q.dl_up || st_q.retrain_done) begin
      retrain_pend <= 1'b0; // [RL13]
    end
  end

  assign set_bw = bw_ok & ((retrain_pend & st_q.retrain_done & st_q.dl_up) |
                           st_q.reliable_fix_change); // [RL13] [RL14]
  assign set_abw = bw_ok & (st_q.auto_change |
                            (ts_hit & ~UPSTREAM)); // [RL15] [RL16]
  assign clr_bw = wr_sts & pstrb[1] & pwdata[plk_pkg::STS_BW_MGMT_FLAG];
  assign clr_abw = wr_sts & pstrb[1] & pwdata[plk_pkg::STS_AUTO_BW_FLAG];

  // a set in the clearing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bw_flag <= 1'b0;
    end else if (!bw_ok) begin
      bw_flag <= 1'b0; // [RL2] [RL5]
    end else if (set_bw) begin
      bw_flag <= 1'b1; // [RL13] [RL14]
    end else if (clr_bw) begin
      bw_flag <= 1'b0; // [RL13]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abw_flag <= 1'b0;
    end else if (!bw_ok) begin
      abw_flag <= 1'b0; // [RL2] [RL5]
    end else if (set_abw) begin
      abw_flag <= 1'b1; // [RL15] [RL16]
    end else if (clr_abw) begin
      abw_flag <= 1'b0; // [RL15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_irq <= 1'b0;
    end else begin
      port_irq <= (bw_flag & ctl_bw_en) |
                  (abw_flag & ctl_abw_en); // [RL3] [RL4] [RL20]
    end
  end

  // ---- slot capability bits
  logic atten_button_present;
  logic power_ctrl_present;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      atten_button_present <= 1'b0;
      power_ctrl_present <= 1'b0;
    end else if (wr_scap && pstrb[0] && cfg_slot) begin
      atten_button_present <= pwdata[plk_pkg::SCAP_ATTEN_BTN]; // [RL17]
      power_ctrl_present <= pwdata[plk_pkg::SCAP_PWR_CTRL];
    end
  end

  // ---- read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      plk_pkg::LINK_CTL_ADDR: begin
        rd_word[plk_pkg::CTL_CLK_PM] = 1'b0; // [RL6]
        rd_word[plk_pkg::CTL_AUTO_WIDTH] = ctl_auto_width & ~cfg_legacy;
        rd_word[plk_pkg::CTL_BW_MGMT_EN] = ctl_bw_en & bw_ok; // [RL5]
        rd_word[plk_pkg::CTL_AUTO_BW_EN] = ctl_abw_en & bw_ok;
      end
      plk_pkg::LINK_STS_ADDR: begin
        rd_word[plk_pkg::STS_SPEED_LSB +: 4] = st_q.cur_speed; // [RL7]
        rd_word[plk_pkg::STS_WIDTH_LSB +: 6] = st_q.neg_width; // [RL8]
        rd_word[plk_pkg::STS_TRAIN_FAIL] = st_q.train_fail; // [RL9]
        rd_word[plk_pkg::STS_TRAIN_ACTIVE] = st_q.train_active; // [RL10]
        rd_word[plk_pkg::STS_SLOT_CLK] = slot_clk;
        rd_word[plk_pkg::STS_DL_ACTIVE] = st_q.dl_up & cfg_dl_cap; // [RL12]
        rd_word[plk_pkg::STS_BW_MGMT_FLAG] = bw_flag & bw_ok;
        rd_word[plk_pkg::STS_AUTO_BW_FLAG] = abw_flag & bw_ok;
      end
      plk_pkg::SLOT_CAP_ADDR: begin
        rd_word[plk_pkg::SCAP_ATTEN_BTN] = atten_button_present & cfg_slot;
        rd_word[plk_pkg::SCAP_PWR_CTRL] = power_ctrl_present & cfg_slot;
      end
      plk_pkg::PORT_CFG_ADDR: begin
        rd_word[plk_pkg::CFG_LEGACY] = cfg_legacy;
        rd_word[plk_pkg::CFG_BW_CAP] = bw_cap_eff;
        rd_word[plk_pkg::CFG_SLOT] = cfg_slot;
        rd_word[plk_pkg::CFG_DL_CAP] = cfg_dl_cap;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // ---- checks
  sequence s_read_taken(logic [ADDR_W-1:0] a);
    psel && !pwrite && access && paddr == a;
  endsequence

  sequence s_retrain_write;
    wr_ctl && pstrb[0] && pwdata[plk_pkg::CTL_RETRAIN];
  endsequence

  chk_width_block_out: assert property ( // [RL1]
    $rose(ctl_auto_width) && !cfg_legacy |=> auto_width_disable)
    else $error("width disable not driven to the link");
  chk_legacy_zero_read: assert property ( // [RL2]
    s_read_taken(plk_pkg::LINK_CTL_ADDR) ##0 cfg_legacy |=>
    prdata[11:9] == 3'h0)
    else $error("legacy mode control bits not zero");
  chk_bw_irq_raise: assert property ( // [RL3]
    bw_flag && ctl_bw_en |=> port_irq)
    else $error("bandwidth management interrupt missing");
  chk_abw_irq_raise: assert property ( // [RL4]
    abw_flag && ctl_abw_en |=> port_irq)
    else $error("autonomous bandwidth interrupt missing");
  chk_nocap_flags_zero: assert property ( // [RL5]
    !bw_ok |=> !bw_flag && !abw_flag && !ctl_bw_en && !ctl_abw_en)
    else $error("bandwidth bits alive without capability");
  chk_clkpm_read_zero: assert property ( // [RL6]
    s_read_taken(plk_pkg::LINK_CTL_ADDR) |=>
    prdata[plk_pkg::CTL_CLK_PM] == 1'b0)
    else $error("clock power management bit read one");
  chk_speed_report: assert property ( // [RL7]
    s_read_taken(plk_pkg::LINK_STS_ADDR) |=>
    prdata[3:0] == $past(st_q.cur_speed))
    else $error("speed field does not follow the link");
  chk_dl_active_gate: assert property ( // [RL12]
    s_read_taken(plk_pkg::LINK_STS_ADDR) ##0 !cfg_dl_cap |=>
    !prdata[plk_pkg::STS_DL_ACTIVE])
    else $error("link active shown without capability");
  chk_retrain_set_bw: assert property ( // [RL13]
    retrain_pend && st_q.retrain_done && st_q.dl_up && bw_ok |=> bw_flag)
    else $error("retrain completion did not set flag");
  chk_w1c_clear: assert property ( // [RL13]
    clr_bw && !set_bw && bw_ok |=> !bw_flag)
    else $error("write one did not clear the flag");
  chk_reliab_set_bw: assert property ( // [RL14]
    st_q.reliable_fix_change && bw_ok |=> bw_flag)
    else $error("reliability change did not set flag");
  chk_auto_set_abw: assert property ( // [RL15]
    st_q.auto_change && bw_ok |=> abw_flag)
    else $error("autonomous change did not set flag");
  chk_slot_bits_gate: assert property ( // [RL17]
    s_read_taken(plk_pkg::SLOT_CAP_ADDR) ##0 !cfg_slot |=>
    prdata[1:0] == 2'h0)
    else $error("slot bits shown without slot capability");
  chk_retrain_pulse: assert property ( // [RL19]
    s_retrain_write |=> retrain_request ##1 !retrain_request)
    else $error("retrain request not a single pulse");
  chk_irq_drop: assert property ( // [RL20]
    !bw_flag && !abw_flag |=> !port_irq)
    else $error("interrupt held with no flag set");
endmodule
`default_nettype wire

// ---- sim/plk_regs_test.sv ----
// self-checking bench for the link control/status register block
`timescale 1ns/10ps
`default_nettype none
module plk_regs_test;
  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready, pslverr;
  plk_pkg::plk_link_status_t link_st;
  plk_pkg::plk_ts_rx_t ts_rx;
  logic upstream_commonclk_strap, downstream_commonclk_strap;
  logic retrain_request, auto_width_disable, port_irq;
  int err_count, checks;
  logic [31:0] rdat;
  logic [31:0] prdata_up;
  logic rerr;
  localparam logic [11:0] A_CTL = plk_pkg::LINK_CTL_ADDR;
  localparam logic [11:0] A_STS = plk_pkg::LINK_STS_ADDR;
  localparam logic [11:0] A_SLOT = plk_pkg::SLOT_CAP_ADDR;
  localparam logic [11:0] A_CFG = plk_pkg::PORT_CFG_ADDR;

  plk_regs dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_st(link_st), .ts_rx(ts_rx),
    .upstream_commonclk_strap(upstream_commonclk_strap),
    .downstream_commonclk_strap(downstream_commonclk_strap),
    .retrain_request(retrain_request),
    .auto_width_disable(auto_width_disable), .port_irq(port_irq));

  // upstream port on the same bus, only its read data is watched
  plk_regs #(.UPSTREAM(1'b1)) dut_up_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata_up), .pready(),
    .pslverr(), .link_st(link_st), .ts_rx(ts_rx),
    .upstream_commonclk_strap(upstream_commonclk_strap),
    .downstream_commonclk_strap(downstream_commonclk_strap),
    .retrain_request(), .auto_width_disable(), .port_irq());

  always #5 pclk = ~pclk;

  task results;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40) begin
      err_count++;
      $display("MISMATCH pready expected 1 seen 0");
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask

  task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    chk(nm, exp, rdat);
    chk("pslverr", 32'h0, {31'h0, rerr});
  endtask

  task settle;
    repeat (4) @(posedge pclk);
  endtask

  // 0 retrain done, 1 reliability change, 2 autonomous change
  task pulse_ev(input int k);
    @(posedge pclk);
    case (k)
      0: link_st.retrain_done <= 1'b1;
      1: link_st.reliable_fix_change <= 1'b1;
      default: link_st.auto_change <= 1'b1;
    endcase
    @(posedge pclk);
    link_st.retrain_done <= 1'b0;
    link_st.reliable_fix_change <= 1'b0;
    link_st.auto_change <= 1'b0;
    settle();
  endtask

  task ts(input int n, input logic b);
    repeat (n) begin
      @(posedge pclk);
      ts_rx <= {1'b1, b};
      @(posedge pclk);
      ts_rx <= 2'h0;
    end
  endtask

  task t_reset_ctl;
    rd("ctl", A_CTL, 32'h0);
    rd("sts", A_STS, 32'h1001);
    chk("sts up", 32'h0001, prdata_up);
    rd("slot", A_SLOT, 32'h0);
    rd("cfg", A_CFG, 32'ha);
    chk("cfg up", 32'h8, prdata_up);
    wr(A_CTL, 32'h0f00);
    rd("ctl", A_CTL, 32'h0e00);
    chk("ctl up", 32'h0200, prdata_up);
    chk("awd", 32'h1, {31'h0, auto_width_disable});
  endtask

  task t_status;
    @(posedge pclk);
    link_st.cur_speed <= 4'h2;
    link_st.neg_width <= 6'h08;
    link_st.train_fail <= 1'b1;
    link_st.train_active <= 1'b1;
    link_st.dl_up <= 1'b1;
    settle();
    rd("sts", A_STS, 32'h3c82);
    wr(A_CFG, 32'h2);
    rd("sts", A_STS, 32'h1c82);
    wr(A_CFG, 32'ha);
  endtask

  task t_retrain;
    wr(A_CTL, 32'h0e20);
    #1;
    chk("retrain", 32'h1, {31'h0, retrain_request});
    @(posedge pclk);
    #1;
    chk("retrain", 32'h0, {31'h0, retrain_request});
    rd("ctl", A_CTL, 32'h0e00);
    pulse_ev(0);
    rd("sts", A_STS, 32'h7c82);
    chk("irq", 32'h1, {31'h0, port_irq});
    wr(A_STS, 32'h5000);
    rd("sts", A_STS, 32'h3c82);
    chk("irq", 32'h0, {31'h0, port_irq});
    wr(A_CTL, 32'h0e20);
    @(posedge pclk);
    link_st.dl_up <= 1'b0;
    repeat (2) @(posedge pclk);
    link_st.dl_up <= 1'b1;
    pulse_ev(0);
    rd("sts", A_STS, 32'h3c82);
  endtask

  task t_auto;
    pulse_ev(1);
    rd("sts", A_STS, 32'h7c82);
    wr(A_STS, 32'h5000);
    pulse_ev(2);
    rd("sts", A_STS, 32'hbc82);
    chk("irq", 32'h1, {31'h0, port_irq});
    wr(A_CTL, 32'h0200);
    settle();
    chk("irq", 32'h0, {31'h0, port_irq});
    wr(A_STS, 32'h9000);
    ts(7, 1'b1);
    ts(1, 1'b0);
    ts(7, 1'b1);
    settle();
    rd("sts", A_STS, 32'h3c82);
    ts(1, 1'b1);
    settle();
    rd("sts", A_STS, 32'hbc82);
    wr(A_STS, 32'h9000);
  endtask

  task t_gating;
    pulse_ev(2);
    wr(A_CTL, 32'h0e00);
    wr(A_CFG, 32'h8);
    rd("sts", A_STS, 32'h3c82);
    rd("ctl", A_CTL, 32'h0200);
    wr(A_CFG, 32'ha);
    rd("sts", A_STS, 32'h3c82);
    pulse_ev(2);
    wr(A_CTL, 32'h0e00);
    wr(A_CFG, 32'hb);
    wr(A_CTL, 32'h0e00);
    rd("ctl", A_CTL, 32'h0);
    rd("sts", A_STS, 32'h3c82);
    chk("awd", 32'h0, {31'h0, auto_width_disable});
    wr(A_CFG, 32'ha);
  endtask

  task t_slot_bus;
    wr(A_SLOT, 32'h3);
    rd("slot", A_SLOT, 32'h0);
    wr(A_CFG, 32'he);
    wr(A_SLOT, 32'h3);
    rd("slot", A_SLOT, 32'h3);
    wr(A_CFG, 32'ha);
    rd("slot", A_SLOT, 32'h0);
    wr(12'h1fc, 32'hffff);
    chk("wr err", 32'h1, {31'h0, rerr});
    xfer(12'h1fc, 1'b0, 32'h0);
    chk("rd err", 32'h1, {31'h0, rerr});
    chk("rd data", 32'h0, rdat);
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    link_st = '0;
    link_st.cur_speed = 4'h1;
    ts_rx = 2'h0;
    upstream_commonclk_strap = 1'b0;
    downstream_commonclk_strap = 1'b1;
    err_count = 0;
    checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    t_reset_ctl();
    t_status();
    t_retrain();
    t_auto();
    t_gating();
    t_slot_bus();
    results();
  end

  // hang guard, far beyond the expected run length
  initial begin
    #500us;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
